// File: rtl/mprf_params.svh
// Purpose: offsets, field positions, reset values for the phy register file
// Assumes: included by bare name from rtl files
// Notes: definitions only
`ifndef MPRF_PARAMS_SVH
`define MPRF_PARAMS_SVH

// management register addresses inside one phy
`define MPRF_RA_BCTL 5'h00
`define MPRF_RA_BSTAT 5'h01
`define MPRF_RA_ID_HI 5'h02
`define MPRF_RA_ID_LO 5'h03
`define MPRF_RA_ADV 5'h04
`define MPRF_RA_PARTNER 5'h05
`define MPRF_RA_CABLE 5'h1d
`define MPRF_RA_SPECIAL 5'h1f

// switch-side register numbers
`define MPRF_SW_GCTL13 8'h0f
`define MPRF_SW_P1_CTL_A 8'h1c
`define MPRF_SW_P1_CTL_B 8'h1d
`define MPRF_SW_P1_CTL_C 8'h1f
`define MPRF_SW_P2_CTL_A 8'h2c
`define MPRF_SW_P2_CTL_B 8'h2d
`define MPRF_SW_P2_CTL_C 8'h2f

// basic control bit positions
`define MPRF_BC_LOOP 14
`define MPRF_BC_F100 13
`define MPRF_BC_AN 12
`define MPRF_BC_PWD 11
`define MPRF_BC_RESTART 9
`define MPRF_BC_FDX 8
`define MPRF_BC_ALGO 5
`define MPRF_BC_FMDI 4
`define MPRF_BC_NOMDIX 3

// control register a bits (speed/duplex/an/advertise)
`define MPRF_A_AN 7
`define MPRF_A_F100 6
`define MPRF_A_FDX 5
`define MPRF_A_PAUSE 4
// control register b bits
`define MPRF_B_LOOP 0
`define MPRF_B_FMDI 1
`define MPRF_B_NOMDIX 2
`define MPRF_B_PWD 3
`define MPRF_B_RESTART 5
// control register c bits
`define MPRF_C_ALGO 7

// advertisement layout
`define MPRF_ADV_PAUSE 10
`define MPRF_ADV_SEL 5'h01

// reset values and the base field position in the global control
`define MPRF_RST_CTL_A 8'h9f
`define MPRF_RST_CTL_B 8'h00
`define MPRF_RST_ALGO 1'b1
`define MPRF_RST_PHYAD 5'h01
`define MPRF_GCTL_LSB 3

`endif

// File: rtl/mprf_pkg.sv
// Purpose: shared types of the phy register file
// Assumes: nothing
// Notes: numeric constants live in mprf_params.svh
package mprf_pkg;
    typedef logic [15:0] mprf_word_t;
    typedef logic [7:0] mprf_byte_t;
    typedef logic [4:0] mprf_addr_t;
    typedef logic [3:0] mprf_nib_t;
endpackage

// File: rtl/mprf_port_ctrl.sv
// Purpose: control bits of one phy port, written from two access paths
// Assumes: at most one path writes in a cycle; mgmt wins if both do
// Notes: both paths see the same flip-flops, so they never disagree
`timescale 1ns/100ps
`include "mprf_params.svh"
module mprf_port_ctrl
    import mprf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // management path writes
    input wire logic bctl_we_i,
    input wire logic adv_we_i,
    input wire mprf_word_t mgmt_wdata_i,
    // switch register path writes
    input wire logic sw_we_a_i,
    input wire logic sw_we_b_i,
    input wire logic sw_we_c_i,
    input wire mprf_byte_t sw_wdata_i,
    // stored state
    output mprf_byte_t ctl_a_o,
    output mprf_byte_t ctl_b_o,
    output logic algo_o,
    output logic restart_pulse_o
);
    mprf_byte_t ctl_a_ff;
    mprf_byte_t ctl_b_ff;
    logic algo_ff;
    logic restart_ff;
    mprf_byte_t nxt_ctl_a;
    mprf_byte_t nxt_ctl_b;
    logic nxt_algo;
    wire mprf_byte_t bctl_a;
    wire mprf_byte_t adv_a;
    wire mprf_byte_t bctl_b;
    wire logic restart_hit;

    // basic control word folded onto register a, bits 4:0 kept
    assign bctl_a = {mgmt_wdata_i[`MPRF_BC_AN], mgmt_wdata_i[`MPRF_BC_F100],
                     mgmt_wdata_i[`MPRF_BC_FDX], ctl_a_ff[4:0]};
    // advertisement word folded onto register a, bits 7:5 kept
    assign adv_a = {ctl_a_ff[7:5], mgmt_wdata_i[`MPRF_ADV_PAUSE], mgmt_wdata_i[8:5]};
    // basic control word folded onto register b; bits 4,6,7 are switch-only
    assign bctl_b = {ctl_b_ff[7:6], mgmt_wdata_i[`MPRF_BC_RESTART], ctl_b_ff[4],
                     mgmt_wdata_i[`MPRF_BC_PWD], mgmt_wdata_i[`MPRF_BC_NOMDIX],
                     mgmt_wdata_i[`MPRF_BC_FMDI], mgmt_wdata_i[`MPRF_BC_LOOP]};

    // write selection, mgmt path first
    assign nxt_ctl_a = bctl_we_i ? bctl_a : adv_we_i ? adv_a : sw_we_a_i ? sw_wdata_i
                     : ctl_a_ff;
    assign nxt_ctl_b = bctl_we_i ? bctl_b : sw_we_b_i ? sw_wdata_i : ctl_b_ff;
    assign nxt_algo = bctl_we_i ? mgmt_wdata_i[`MPRF_BC_ALGO]
                    : sw_we_c_i ? sw_wdata_i[`MPRF_C_ALGO] : algo_ff;
    // a restart is a written one, whichever path wrote it
    assign restart_hit = (bctl_we_i & mgmt_wdata_i[`MPRF_BC_RESTART])
                       | (~bctl_we_i & sw_we_b_i & sw_wdata_i[`MPRF_B_RESTART]);

    // control storage with documented reset values
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctl_a_ff <= `MPRF_RST_CTL_A;
            ctl_b_ff <= `MPRF_RST_CTL_B;
            algo_ff <= `MPRF_RST_ALGO;
            restart_ff <= 1'b0;
        end else begin
            ctl_a_ff <= nxt_ctl_a;
            ctl_b_ff <= nxt_ctl_b;
            algo_ff <= nxt_algo;
            restart_ff <= restart_hit;
        end
    end

    assign ctl_a_o = ctl_a_ff;
    assign ctl_b_o = ctl_b_ff;
    assign algo_o = algo_ff;
    assign restart_pulse_o = restart_ff;
endmodule // mprf_port_ctrl

// File: rtl/mprf_lane_route.sv
// Purpose: line pair steering for far-end loopback and forced mdi
// Assumes: 4-bit symbol lanes per port, port p at bits 4p+3:4p
// Notes: outputs registered, one cycle of latency on every path
`timescale 1ns/100ps
`include "mprf_params.svh"
module mprf_lane_route
    import mprf_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // per-port controls
    input wire logic [1:0] far_loop_i,
    input wire logic [1:0] force_mdi_i,
    // symbol lanes
    input wire logic [7:0] mac_tx_data_i,
    input wire logic [7:0] line_receive_pair_i,
    output logic [7:0] line_transmit_pair_o,
    output logic [7:0] line_receive_pair_o,
    output logic [1:0] line_receive_pair_oe_n_o
);
    logic [7:0] tx_pair_ff;
    logic [7:0] rx_pair_ff;
    logic [1:0] oe_n_ff;

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            wire mprf_nib_t sym;
            // the other phy looping sends this port's own receive back out
            assign sym = far_loop_i[1-p] ? line_receive_pair_i[4*p+3:4*p]
                       : mac_tx_data_i[4*p+3:4*p];
            // forced mdi moves the transmitter onto the receive pins
            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    tx_pair_ff[4*p+3:4*p] <= 4'h0;
                    rx_pair_ff[4*p+3:4*p] <= 4'h0;
                    oe_n_ff[p] <= 1'b1;
                end else begin
                    tx_pair_ff[4*p+3:4*p] <= force_mdi_i[p] ? 4'h0 : sym;
                    rx_pair_ff[4*p+3:4*p] <= force_mdi_i[p] ? sym : 4'h0;
                    oe_n_ff[p] <= ~force_mdi_i[p];
                end
            end
        end
    endgenerate

    assign line_transmit_pair_o = tx_pair_ff;
    assign line_receive_pair_o = rx_pair_ff;
    assign line_receive_pair_oe_n_o = oe_n_ff;
endmodule // mprf_lane_route

// File: rtl/mprf_regfile.sv
// Purpose: management register file of the two integrated phys
// Assumes: management frames already deserialised into one-cycle requests
// Notes: switch register path reaches the aliased control bits
`timescale 1ns/100ps
`include "mprf_params.svh"
module mprf_regfile
    import mprf_pkg::*;
#(
    parameter mprf_word_t ID_HIGH = 16'h5a5a, // arbitrary identifier value
    parameter mprf_word_t ID_LOW = 16'ha5a0 // arbitrary identifier value
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // management access
    input wire logic mgmt_req_i,
    input wire logic mgmt_wr_i,
    input wire mprf_addr_t mgmt_phyad_i,
    input wire mprf_addr_t mgmt_regad_i,
    input wire mprf_word_t mgmt_wdata_i,
    output logic mgmt_ack_o,
    output logic mgmt_hit_o,
    output mprf_word_t mgmt_rdata_o,
    // switch register access
    input wire logic sw_req_i,
    input wire logic sw_wr_i,
    input wire mprf_byte_t sw_addr_i,
    input wire mprf_byte_t sw_wdata_i,
    output logic sw_ack_o,
    output mprf_byte_t sw_rdata_o,
    // phy state shown through read-only registers
    input wire mprf_word_t phy1_status_i,
    input wire mprf_word_t phy2_status_i,
    input wire mprf_word_t phy1_partner_i,
    input wire mprf_word_t phy2_partner_i,
    input wire mprf_word_t phy1_special_i,
    input wire mprf_word_t phy2_special_i,
    input wire mprf_word_t cable_status_i,
    // writes forwarded to the special and cable registers
    output logic ext_wr_o,
    output logic ext_wr_phy_o,
    output mprf_addr_t ext_wr_regad_o,
    output mprf_word_t ext_wr_data_o,
    // per-port phy controls, bit 0 is phy one
    output logic [1:0] autoneg_on_o,
    output logic [1:0] force_100_o,
    output logic [1:0] force_full_o,
    output logic [1:0] power_down_o,
    output logic [1:0] renegotiate_request_o,
    output logic [1:0] crossover_algorithm_select_o,
    output logic [1:0] force_mdi_o,
    output logic [1:0] mdix_disable_o,
    output logic [1:0] far_loop_o,
    // symbol lanes
    input wire logic [7:0] mac_tx_data_i,
    input wire logic [7:0] line_receive_pair_i,
    output logic [7:0] line_transmit_pair_o,
    output logic [7:0] line_receive_pair_o,
    output logic [1:0] line_receive_pair_oe_n_o
);
    // basic control word assembled from the aliased control bytes
    function automatic mprf_word_t bctl_word(input mprf_byte_t a, input mprf_byte_t b,
                                             input logic algo);
        mprf_word_t w;
        w = 16'h0000;
        w[`MPRF_BC_LOOP] = b[`MPRF_B_LOOP];
        w[`MPRF_BC_F100] = a[`MPRF_A_F100];
        w[`MPRF_BC_AN] = a[`MPRF_A_AN];
        w[`MPRF_BC_PWD] = b[`MPRF_B_PWD];
        w[`MPRF_BC_RESTART] = b[`MPRF_B_RESTART];
        w[`MPRF_BC_FDX] = a[`MPRF_A_FDX];
        w[`MPRF_BC_ALGO] = algo;
        w[`MPRF_BC_FMDI] = b[`MPRF_B_FMDI];
        w[`MPRF_BC_NOMDIX] = b[`MPRF_B_NOMDIX];
        return w;
    endfunction

    // advertisement word, selector fixed to the 802.3 code
    function automatic mprf_word_t adv_word(input mprf_byte_t a);
        mprf_word_t w;
        w = 16'h0000;
        w[`MPRF_ADV_PAUSE] = a[`MPRF_A_PAUSE];
        w[8:5] = a[3:0];
        w[4:0] = `MPRF_ADV_SEL;
        return w;
    endfunction

    logic [4:0] phyad_base_ff;
    logic mgmt_ack_ff;
    logic mgmt_hit_ff;
    mprf_word_t mgmt_rdata_ff;
    logic sw_ack_ff;
    mprf_byte_t sw_rdata_ff;
    logic ext_wr_ff;
    logic ext_wr_phy_ff;
    mprf_addr_t ext_wr_regad_ff;
    mprf_word_t ext_wr_data_ff;
    mprf_word_t nxt_mgmt_rdata;
    mprf_byte_t nxt_sw_rdata;

    wire mprf_addr_t phyad_second;
    wire logic sel_p1;
    wire logic sel_p2;
    wire logic mgmt_hit;
    wire logic mgmt_we;
    wire logic reg_known;
    wire logic ext_target;
    wire logic [1:0] bctl_we;
    wire logic [1:0] adv_we;
    wire logic [1:0] sw_we_a;
    wire logic [1:0] sw_we_b;
    wire logic [1:0] sw_we_c;
    wire logic sw_we_gctl;
    mprf_byte_t ctl_a [2];
    mprf_byte_t ctl_b [2];
    logic [1:0] algo;
    wire mprf_word_t bctl_rd [2];
    mprf_word_t status_rd [2];
    mprf_word_t partner_rd [2];
    mprf_word_t special_rd [2];

    // address match against the programmed base, second phy sits one above
    assign phyad_second = mprf_addr_t'(phyad_base_ff + 5'h01);
    assign sel_p1 = (mgmt_phyad_i == phyad_base_ff);
    assign sel_p2 = (mgmt_phyad_i == phyad_second) & ~sel_p1;
    assign mgmt_hit = sel_p1 | sel_p2;
    assign mgmt_we = mgmt_req_i & mgmt_wr_i & mgmt_hit;

    // supported register set; 0x1d only behind the second phy
    assign reg_known = (mgmt_regad_i <= `MPRF_RA_PARTNER)
                     | (mgmt_regad_i == `MPRF_RA_SPECIAL)
                     | (sel_p2 & (mgmt_regad_i == `MPRF_RA_CABLE));
    assign ext_target = reg_known & ((mgmt_regad_i == `MPRF_RA_SPECIAL)
                                   | (mgmt_regad_i == `MPRF_RA_CABLE));

    // per-port write strobes from both paths; other addresses get no control strobe here
    assign bctl_we = {2{mgmt_we & (mgmt_regad_i == `MPRF_RA_BCTL)}} & {sel_p2, sel_p1};
    assign adv_we = {2{mgmt_we & (mgmt_regad_i == `MPRF_RA_ADV)}} & {sel_p2, sel_p1};
    assign sw_we_a = {2{sw_req_i & sw_wr_i}} & {sw_addr_i == `MPRF_SW_P2_CTL_A,
                                                 sw_addr_i == `MPRF_SW_P1_CTL_A};
    assign sw_we_b = {2{sw_req_i & sw_wr_i}} & {sw_addr_i == `MPRF_SW_P2_CTL_B,
                                                 sw_addr_i == `MPRF_SW_P1_CTL_B};
    assign sw_we_c = {2{sw_req_i & sw_wr_i}} & {sw_addr_i == `MPRF_SW_P2_CTL_C,
                                                 sw_addr_i == `MPRF_SW_P1_CTL_C};
    assign sw_we_gctl = sw_req_i & sw_wr_i & (sw_addr_i == `MPRF_SW_GCTL13);

    assign status_rd[0] = phy1_status_i;
    assign status_rd[1] = phy2_status_i;
    assign partner_rd[0] = phy1_partner_i;
    assign partner_rd[1] = phy2_partner_i;
    assign special_rd[0] = phy1_special_i;
    assign special_rd[1] = phy2_special_i;

    // one control store per phy, shared by both access paths
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_phy
            mprf_port_ctrl u_ctrl (
                .sys_clk_i(sys_clk_i),
                .srst_i(srst_i),
                .bctl_we_i(bctl_we[p]),
                .adv_we_i(adv_we[p]),
                .mgmt_wdata_i(mgmt_wdata_i),
                .sw_we_a_i(sw_we_a[p]),
                .sw_we_b_i(sw_we_b[p]),
                .sw_we_c_i(sw_we_c[p]),
                .sw_wdata_i(sw_wdata_i),
                .ctl_a_o(ctl_a[p]),
                .ctl_b_o(ctl_b[p]),
                .algo_o(algo[p]),
                .restart_pulse_o(renegotiate_request_o[p])
            );
            assign bctl_rd[p] = bctl_word(ctl_a[p], ctl_b[p], algo[p]);
            // control bits straight from the shared store
            assign autoneg_on_o[p] = ctl_a[p][`MPRF_A_AN];
            assign force_100_o[p] = ctl_a[p][`MPRF_A_F100];
            assign force_full_o[p] = ctl_a[p][`MPRF_A_FDX];
            assign power_down_o[p] = ctl_b[p][`MPRF_B_PWD];
            assign crossover_algorithm_select_o[p] = algo[p];
            assign force_mdi_o[p] = ctl_b[p][`MPRF_B_FMDI];
            assign mdix_disable_o[p] = ctl_b[p][`MPRF_B_NOMDIX];
            assign far_loop_o[p] = ctl_b[p][`MPRF_B_LOOP];
        end
    endgenerate

    // management read selection; index 1 means the second phy
    always_comb begin
        nxt_mgmt_rdata = 16'h0000;
        if (mgmt_hit && reg_known) begin
            case (mgmt_regad_i)
                `MPRF_RA_BCTL: nxt_mgmt_rdata = bctl_rd[sel_p2];
                `MPRF_RA_BSTAT: nxt_mgmt_rdata = status_rd[sel_p2];
                `MPRF_RA_ID_HI: nxt_mgmt_rdata = ID_HIGH;
                `MPRF_RA_ID_LO: nxt_mgmt_rdata = ID_LOW;
                `MPRF_RA_ADV: nxt_mgmt_rdata = adv_word(ctl_a[sel_p2]);
                `MPRF_RA_PARTNER: nxt_mgmt_rdata = partner_rd[sel_p2];
                `MPRF_RA_CABLE: nxt_mgmt_rdata = cable_status_i;
                `MPRF_RA_SPECIAL: nxt_mgmt_rdata = special_rd[sel_p2];
                default: nxt_mgmt_rdata = 16'h0000;
            endcase
        end
    end

    // switch-side read selection, unknown numbers read zero
    always_comb begin
        nxt_sw_rdata = 8'h00;
        case (sw_addr_i)
            `MPRF_SW_GCTL13: nxt_sw_rdata = {phyad_base_ff, 3'h0};
            `MPRF_SW_P1_CTL_A: nxt_sw_rdata = ctl_a[0];
            `MPRF_SW_P1_CTL_B: nxt_sw_rdata = ctl_b[0];
            `MPRF_SW_P1_CTL_C: nxt_sw_rdata = {algo[0], 7'h00};
            `MPRF_SW_P2_CTL_A: nxt_sw_rdata = ctl_a[1];
            `MPRF_SW_P2_CTL_B: nxt_sw_rdata = ctl_b[1];
            `MPRF_SW_P2_CTL_C: nxt_sw_rdata = {algo[1], 7'h00};
            default: nxt_sw_rdata = 8'h00;
        endcase
    end

    // phy address base; reset value places the phys at 1 and 2
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            phyad_base_ff <= `MPRF_RST_PHYAD;
        end else if (sw_we_gctl) begin
            phyad_base_ff <= sw_wdata_i[7:`MPRF_GCTL_LSB];
        end
    end

    // management answer one cycle after the request, even for a miss
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mgmt_ack_ff <= 1'b0;
            mgmt_hit_ff <= 1'b0;
            mgmt_rdata_ff <= 16'h0000;
        end else begin
            mgmt_ack_ff <= mgmt_req_i;
            mgmt_hit_ff <= mgmt_req_i & mgmt_hit;
            mgmt_rdata_ff <= mgmt_req_i ? nxt_mgmt_rdata : mgmt_rdata_ff;
        end
    end

    // switch answer one cycle after the request
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sw_ack_ff <= 1'b0;
            sw_rdata_ff <= 8'h00;
        end else begin
            sw_ack_ff <= sw_req_i;
            sw_rdata_ff <= sw_req_i ? nxt_sw_rdata : sw_rdata_ff;
        end
    end

    // special and cable registers live outside; pass their writes on
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ext_wr_ff <= 1'b0;
            ext_wr_phy_ff <= 1'b0;
            ext_wr_regad_ff <= 5'h00;
            ext_wr_data_ff <= 16'h0000;
        end else begin
            ext_wr_ff <= mgmt_we & ext_target;
            if (mgmt_we && ext_target) begin
                ext_wr_phy_ff <= sel_p2;
                ext_wr_regad_ff <= mgmt_regad_i;
                ext_wr_data_ff <= mgmt_wdata_i;
            end
        end
    end

    // loopback and forced mdi steering of the line pairs
    mprf_lane_route u_route (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .far_loop_i(far_loop_o),
        .force_mdi_i(force_mdi_o),
        .mac_tx_data_i(mac_tx_data_i),
        .line_receive_pair_i(line_receive_pair_i),
        .line_transmit_pair_o(line_transmit_pair_o),
        .line_receive_pair_o(line_receive_pair_o),
        .line_receive_pair_oe_n_o(line_receive_pair_oe_n_o)
    );

    assign mgmt_ack_o = mgmt_ack_ff;
    assign mgmt_hit_o = mgmt_hit_ff;
    assign mgmt_rdata_o = mgmt_rdata_ff;
    assign sw_ack_o = sw_ack_ff;
    assign sw_rdata_o = sw_rdata_ff;
    assign ext_wr_o = ext_wr_ff;
    assign ext_wr_phy_o = ext_wr_phy_ff;
    assign ext_wr_regad_o = ext_wr_regad_ff;
    assign ext_wr_data_o = ext_wr_data_ff;
endmodule // mprf_regfile

// File: verif/mprf_regfile_asserts.sv
// Purpose: port checks
// Assumes: bound from the bench
// Notes: one clock domain
`timescale 1ns/100ps
module mprf_regfile_asserts
    import mprf_pkg::*;
(
    // inputs
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic mgmt_req_i,
    input wire logic mgmt_wr_i,
    input wire mprf_addr_t mgmt_regad_i,
    input wire logic sw_req_i,
    input wire logic sw_wr_i,
    input wire logic [7:0] line_receive_pair_i,
    // outputs
    input wire logic mgmt_ack_o,
    input wire logic mgmt_hit_o,
    input wire mprf_word_t mgmt_rdata_o,
    input wire logic [1:0] autoneg_on_o,
    input wire logic [1:0] renegotiate_request_o,
    input wire logic [1:0] far_loop_o,
    input wire logic [1:0] force_mdi_o,
    input wire logic [7:0] line_transmit_pair_o,
    input wire logic [1:0] line_receive_pair_oe_n_o
);
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // unsupported numbers
    wire unsup = (mgmt_regad_i > 5'h05) && (mgmt_regad_i != 5'h1d) && (mgmt_regad_i != 5'h1f);

    ack_timing_a: assert property (mgmt_req_i |=> mgmt_ack_o)
        else $error("no answer");
    miss_zero_a: assert property (mgmt_ack_o && !mgmt_hit_o |-> mgmt_rdata_o == 16'h0000)
        else $error("miss data");
    unsup_zero_a: assert property (mgmt_req_i && !mgmt_wr_i && unsup |=> mgmt_rdata_o == 16'h0000)
        else $error("unsup data");
    rsvd_bits_a: assert property (mgmt_req_i && !mgmt_wr_i && mgmt_regad_i == 5'h00
        |=> (mgmt_rdata_o & 16'h84c0) == 16'h0000)
        else $error("reserved bit set");
    ctl_reset_a: assert property ($past(srst_i) |-> autoneg_on_o == 2'b11 && far_loop_o == 2'b00)
        else $error("bad reset");
    restart_cause_a: assert property (renegotiate_request_o != 2'b00
        |-> $past(mgmt_req_i && mgmt_wr_i || sw_req_i && sw_wr_i))
        else $error("stray restart");
    loop_one_a: assert property ($past(far_loop_o[0] && !force_mdi_o[1])
        |-> line_transmit_pair_o[7:4] == $past(line_receive_pair_i[7:4]))
        else $error("port two loop");
    loop_two_a: assert property ($past(far_loop_o[1] && !force_mdi_o[0])
        |-> line_transmit_pair_o[3:0] == $past(line_receive_pair_i[3:0]))
        else $error("port one loop");
    mdi_drive_a: assert property (force_mdi_o[0] |=> !line_receive_pair_oe_n_o[0])
        else $error("mdi not driven");
endmodule // mprf_regfile_asserts

// File: verif/mprf_mgmt_host.sv
// Purpose: management requester
// Assumes: answer one cycle later
// Notes: released phy address and write data inverted
`timescale 1ns/100ps
module mprf_mgmt_host
    import mprf_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // request side
    output logic req_o = 1'b0,
    output logic wr_o = 1'b0,
    output mprf_addr_t phyad_o = 5'h00,
    output mprf_addr_t regad_o = 5'h00,
    output mprf_word_t wdata_o = 16'h0000,
    // answer side
    input wire logic ack_i,
    input wire logic hit_i,
    input wire mprf_word_t rdata_i
);
    // one access, answer read while it stands
    task automatic xfer(input logic w, input mprf_addr_t pa, input mprf_addr_t ra,
        input mprf_word_t wd, output logic a, output logic h, output mprf_word_t rd);
        @(posedge sys_clk_i);
        req_o <= 1'b1;
        wr_o <= w;
        phyad_o <= pa;
        regad_o <= ra;
        wdata_o <= wd;
        @(posedge sys_clk_i);
        req_o <= 1'b0;
        phyad_o <= ~pa;
        wdata_o <= ~wd;
        @(negedge sys_clk_i);
        a = ack_i;
        h = hit_i;
        rd = rdata_i;
    endtask
endmodule // mprf_mgmt_host

// File: verif/mprf_regfile_tb.sv
// Purpose: bench
// Assumes: model mirrors control state
// Notes: lanes checked by the checker
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module mprf_regfile_tb
    import mprf_pkg::*;
;
    localparam mprf_word_t ID_H = 16'h1357; // arbitrary value
    localparam mprf_word_t ID_L = 16'h2468; // arbitrary value
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic mgmt_req_i, mgmt_wr_i, mgmt_ack_o, mgmt_hit_o, sw_ack_o;
    logic sw_req_i = 1'b0;
    logic sw_wr_i = 1'b0;
    mprf_addr_t mgmt_phyad_i, mgmt_regad_i, base;
    mprf_word_t mgmt_wdata_i, mgmt_rdata_o, phy1_status_i, phy2_status_i, phy1_partner_i;
    mprf_word_t phy2_partner_i, phy1_special_i, phy2_special_i, cable_status_i;
    mprf_byte_t sw_addr_i = 8'h00;
    mprf_byte_t sw_wdata_i = 8'h00;
    mprf_byte_t sw_rdata_o, rb, b;
    logic [1:0] autoneg_on_o, force_100_o, force_full_o, power_down_o, renegotiate_request_o;
    logic [1:0] crossover_algorithm_select_o, force_mdi_o, mdix_disable_o, far_loop_o;
    logic [7:0] mac_tx_data_i = 8'h00;
    logic [7:0] line_receive_pair_i = 8'h00;
    logic [7:0] line_transmit_pair_o;
    logic [1:0] line_receive_pair_oe_n_o;
    mprf_word_t bc [2];
    mprf_word_t adv [2];
    int seed = 32'hc8fc;
    int error_cnt = 0;
    int cmp_count = 0;
    int v;

    mprf_regfile #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) mprf_regfile_i (.*, .ext_wr_o(),
        .ext_wr_phy_o(), .ext_wr_regad_o(), .ext_wr_data_o(), .line_receive_pair_o());
    mprf_mgmt_host mprf_mgmt_host_i (.sys_clk_i, .req_o(mgmt_req_i), .wr_o(mgmt_wr_i),
        .phyad_o(mgmt_phyad_i), .regad_o(mgmt_regad_i), .wdata_o(mgmt_wdata_i),
        .ack_i(mgmt_ack_o), .hit_i(mgmt_hit_o), .rdata_i(mgmt_rdata_o));

    // clock, random lanes
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        mac_tx_data_i <= 8'($random(seed));
        line_receive_pair_i <= 8'($random(seed));
    end

    // expected read
    function automatic mprf_word_t exp_rd(int p, mprf_addr_t r);
        case (r)
            5'h00: return bc[p];
            5'h01: return p ? phy2_status_i : phy1_status_i;
            5'h02: return ID_H;
            5'h03: return ID_L;
            5'h04: return adv[p];
            5'h05: return p ? phy2_partner_i : phy1_partner_i;
            5'h1d: return p ? cable_status_i : 16'h0000;
            5'h1f: return p ? phy2_special_i : phy1_special_i;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [7:0] ctl(int p);
        return {far_loop_o[p], force_100_o[p], autoneg_on_o[p], power_down_o[p],
            force_full_o[p], crossover_algorithm_select_o[p], force_mdi_o[p], mdix_disable_o[p]};
    endfunction

    // management access
    task automatic mg(input logic w, input mprf_addr_t pa, input mprf_addr_t ra,
        input mprf_word_t wd);
        logic a, h;
        mprf_word_t rd;
        int p;
        p = (pa == base) ? 0 : (pa == base + 5'h01) ? 1 : 2;
        mprf_mgmt_host_i.xfer(w, pa, ra, wd, a, h, rd);
        `CHK(a, 1'b1)
        `CHK(h, p < 2)
        if (!w) `CHK(rd, p < 2 ? exp_rd(p, ra) : 16'h0000)
        if (w && p < 2 && ra == 5'h00) bc[p] = wd & 16'h7b38;
        if (w && p < 2 && ra == 5'h04) adv[p] = (wd & 16'h05e0) | 16'h0001;
        if (p < 2) `CHK(ctl(p), {bc[p][14:11], bc[p][8], bc[p][5:3]})
    endtask

    // switch access
    task automatic sw(input logic w, input mprf_byte_t ad, input mprf_byte_t wd);
        @(posedge sys_clk_i);
        sw_req_i <= 1'b1;
        sw_wr_i <= w;
        sw_addr_i <= ad;
        sw_wdata_i <= wd;
        @(posedge sys_clk_i);
        sw_req_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK(sw_ack_o, 1'b1)
        rb = sw_rdata_o;
    endtask

    // reset
    task automatic do_reset(int n);
        srst_i <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        base = 5'h01;
        bc = '{16'h1020, 16'h1020};
        adv = '{16'h05e1, 16'h05e1};
    endtask

    // all registers, three addresses
    task automatic sweep(logic w);
        for (v = 0; v < 96; v++) mg(w, 5'(v / 32 + 1), 5'(v), 16'($random(seed)));
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog, about 26 times the run
    initial begin
        #(20 * 20000);
        error_cnt++;
        $display("[FAIL] %0t watchdog", $time);
        end_of_test();
    end

    initial begin
        {phy1_status_i, phy2_status_i, phy1_partner_i} = {$random(seed), 16'($random(seed))};
        {phy2_partner_i, phy1_special_i} = $random(seed);
        {phy2_special_i, cable_status_i} = $random(seed);
        do_reset(16);
        sweep(1'b0);
        sweep(1'b1);
        sweep(1'b0);
        $display("sweep done");
        // random control writes
        for (v = 0; v < 32; v++) begin
            mg(1'b1, 5'(v % 2 + 1), 5'h00, 16'($random(seed)));
            mg(1'b0, 5'(v % 2 + 1), 5'h00, 16'h0000);
        end
        $display("control done");
        // alias
        for (v = 0; v < 2; v++) begin
            b = 8'($random(seed));
            sw(1'b1, v ? 8'h2d : 8'h1d, b);
            {bc[v][14], bc[v][4], bc[v][3], bc[v][11], bc[v][9]} = {b[0], b[1], b[2], b[3], b[5]};
            mg(1'b0, 5'(v + 1), 5'h00, 16'h0000);
            sw(1'b0, v ? 8'h2d : 8'h1d, 8'h00);
            `CHK(rb, b)
            sw(1'b0, v ? 8'h2c : 8'h1c, 8'h00);
            `CHK(rb, {bc[v][12], bc[v][13], bc[v][8], adv[v][10], adv[v][8:5]})
        end
        $display("alias done");
        // moved addresses, with wrap
        for (v = 0; v < 2; v++) begin
            base = v ? 5'h1f : 5'h0a;
            sw(1'b1, 8'h0f, {base, 3'b000});
            mg(1'b0, base, 5'h00, 16'h0000);
            mg(1'b0, base + 5'h01, 5'h04, 16'h0000);
            mg(1'b0, 5'h01, 5'h00, 16'h0000);
        end
        $display("address done");
        do_reset(2);
        mg(1'b0, 5'h01, 5'h00, 16'h0000);
        mg(1'b0, 5'h02, 5'h00, 16'h0000);
        $display("reset done");
        end_of_test();
    end
endmodule // mprf_regfile_tb

bind mprf_regfile mprf_regfile_asserts mprf_regfile_asserts_i (.*);
